//--- common/fci_pkg.sv
// Constants and types for the flash command host controller
package fci_pkg;

  // ----------------------------------------
  // Clock and pin timing
  // ----------------------------------------
  localparam int CLK_NS = 50;
  localparam int T_WE_NS = 50;
  localparam int T_ACC_NS = 85;
  localparam int T_RB_NS = 100;
  localparam int T_WE_CYC = (T_WE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RB_CYC = (T_RB_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------
  // Flash command bytes and status bits
  // ----------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
  localparam logic [7:0] CMD_WRITE_SETUP_ALT = 8'h10;
  localparam int SR_READY_BIT = 7;
  localparam int SR_SUSP_BIT = 6;
  localparam int SR_SUPPLY_LOW_BIT = 3;
  localparam logic [7:0] SR_RESET = 8'h80;
  localparam logic [7:0] SR_ERR_MASK = 8'h38;
  localparam logic [19:0] ID_MFR_ADDR = 20'h00000;
  localparam logic [19:0] ID_DEV_ADDR = 20'h00001;

  // ----------------------------------------
  // Host operations
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_READ_ARRAY = 3'b000,
    OP_READ_ID = 3'b001,
    OP_READ_STATUS = 3'b010,
    OP_CLEAR = 3'b011,
    OP_ERASE = 3'b100,
    OP_WRITE = 3'b101,
    OP_SUSPEND = 3'b110,
    OP_RESUME = 3'b111
  } fci_op_e;
  localparam logic [7:0] OP_CMD [8] = '{CMD_READ_ARRAY, CMD_READ_ID, CMD_READ_STATUS,
    CMD_CLEAR_STATUS, CMD_ERASE_SETUP, CMD_WRITE_SETUP, CMD_SUSPEND, CMD_CONFIRM};
  localparam logic [7:0] OP_W2_MASK = 8'h30;
  localparam logic [7:0] OP_WAIT_MASK = 8'hF0;
  localparam logic [7:0] OP_READ_MASK = 8'hF7;
  localparam logic [7:0] OP_SR_MASK = 8'hF4;
  localparam logic [7:0] OP_SUPPLY_MASK = 8'h30;
  localparam logic [7:0] OP_SUSP_OK_MASK = 8'h85;

  // ----------------------------------------
  // Register map and bus answers
  // ----------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_POWER = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

//--- common/fci_cyc_if.sv
// Single pin cycle request between sequencer and pin engine
`timescale 1ns/1ps
interface fci_cyc_if #(parameter int ADDR_W = 20);
  logic req;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport ctl(output req, wr, addr, wdata, input done, rdata);
  modport eng(input req, wr, addr, wdata, output done, rdata);
endinterface

//--- hw/fci_pin_engine.sv
// Pin engine: one strobed write or read cycle on the flash pins
`timescale 1ns/1ps
module fci_pin_engine import fci_pkg::*; #(
  parameter int ADDR_W = 20
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Cycle requests
  fci_cyc_if.eng cyc,
  // Flash pins
  output logic [ADDR_W-1:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in,
  output logic chip_enable_n,
  output logic output_enable_n,
  output logic write_enable_n
);

  typedef enum logic [2:0] {
    E_IDLE = 3'b000,
    E_SETUP = 3'b001,
    E_STROBE = 3'b010,
    E_HOLD = 3'b011,
    E_READ = 3'b100,
    E_RECOV = 3'b101
  } fci_eng_e;

  localparam logic [3:0] WE_LAST = 4'(T_WE_CYC - 1);
  localparam logic [3:0] RD_LAST = 4'(T_ACC_CYC + SYNC_STAGES - 1);

  if (T_ACC_CYC + SYNC_STAGES > 15 || T_WE_CYC > 15) begin : g_bad_timing
    $error("pin timing counts exceed counter width");
  end

  fci_eng_e state_q;
  logic [3:0] cnt_q;
  logic [7:0] dq_s1_q;
  logic [7:0] dq_s2_q;
  logic done_q;
  logic [7:0] rdata_q;

  assign cyc.done = done_q;
  assign cyc.rdata = rdata_q;

  // ----------------------------------------
  // Data input synchroniser
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    dq_s1_q <= flash_dq_in;
    dq_s2_q <= dq_s1_q;
  end

  // ----------------------------------------
  // Cycle sequencing
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= E_IDLE;
      cnt_q <= 4'h0;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
      flash_addr <= '0;
      flash_dq_out <= 8'h00;
      flash_dq_oe <= 1'b0;
      chip_enable_n <= 1'b1;
      output_enable_n <= 1'b1;
      write_enable_n <= 1'b1;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        E_IDLE: if (cyc.req) begin
          flash_addr <= cyc.addr;
          flash_dq_out <= cyc.wdata;
          chip_enable_n <= 1'b0;
          cnt_q <= 4'h0;
          flash_dq_oe <= cyc.wr;
          output_enable_n <= cyc.wr;
          state_q <= cyc.wr ? E_SETUP : E_READ;
        end
        E_SETUP: begin
          write_enable_n <= 1'b0;
          state_q <= E_STROBE;
        end
        E_STROBE: if (cnt_q == WE_LAST) begin
          write_enable_n <= 1'b1; // Address and data latch on this rising edge
          state_q <= E_HOLD;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
        E_HOLD: begin
          chip_enable_n <= 1'b1;
          flash_dq_oe <= 1'b0;
          done_q <= 1'b1;
          state_q <= E_RECOV;
        end
        E_READ: if (cnt_q == RD_LAST) begin
          rdata_q <= dq_s2_q;
          output_enable_n <= 1'b1; // Release between reads refreshes status
          chip_enable_n <= 1'b1;
          done_q <= 1'b1;
          state_q <= E_RECOV;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
        E_RECOV: state_q <= E_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_we_pulse_width: assert property ($fell(write_enable_n) |=> write_enable_n)
    else $error("write strobe not one cycle wide");
  chk_write_data_stable: assert property (!write_enable_n |=>
    flash_dq_oe && $stable(flash_dq_out) && $stable(flash_addr))
    else $error("write data or address moved around strobe");
  chk_read_release: assert property ($rose(output_enable_n) |-> chip_enable_n ##1
    (output_enable_n && chip_enable_n))
    else $error("enables not released between reads");
  chk_no_bus_fight: assert property (!output_enable_n |-> !flash_dq_oe)
    else $error("host drives data while flash outputs enabled");

endmodule

//--- hw/fci_flash_host.sv
// Flash command host controller with register access over AXI4-Lite
`timescale 1ns/1ps
// Contract
// - Command FFH returns device to array reads.
// - Host leaves identifier mode by another command.
// - Status latched on enable fall; toggle between reads.
// - Low-supply flag must be cleared before writes.
// - Erase is 20H then D0H in block.
// - Byte write is 40H then address and data.
module fci_flash_host import fci_pkg::*; #(
  parameter int ADDR_W = 20
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Flash pins
  output logic [ADDR_W-1:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in,
  output logic chip_enable_n,
  output logic output_enable_n,
  output logic write_enable_n,
  output logic powerdown_input_n,
  input wire logic ready_busy_output
);

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_WR1 = 3'b001,
    M_WR2 = 3'b010,
    M_SETTLE = 3'b011,
    M_POLL = 3'b100,
    M_READ = 3'b101
  } fci_main_e;
  localparam logic [3:0] RB_LAST = 4'(T_RB_CYC - 1);
  if (ADDR_W < 1 || ADDR_W > 24 || T_RB_CYC > 15) begin : g_bad_param
    $error("address width or settle count out of range");
  end
  fci_cyc_if #(.ADDR_W(ADDR_W)) cyc ();
  fci_pin_engine #(.ADDR_W(ADDR_W)) u_engine (
    .aclk(aclk),
    .aresetn(aresetn),
    .cyc(cyc),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in),
    .chip_enable_n(chip_enable_n),
    .output_enable_n(output_enable_n),
    .write_enable_n(write_enable_n)
  );

  fci_main_e state_q;
  fci_op_e op_q;
  logic req_q;
  logic [3:0] rb_cnt_q;
  logic rb_s1_q, rb_s2_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] result_q;
  logic [7:0] sr_q;
  logic supply_low_q, susp_q, refused_q, pwd_q;
  logic aw_full_q, w_full_q;
  logic [7:0] awaddr_q;
  logic [31:0] bus_wdata_q;
  logic [3:0] wstrb_q;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire do_wr = aw_full_q && w_full_q && !s_axi_bvalid;
  wire wr_hit = (awaddr_q <= REG_POWER) && (awaddr_q[1:0] == 2'b00);
  wire wr_cmd = do_wr && (awaddr_q == REG_CMD) && wstrb_q[0];
  wire wr_addr = do_wr && (awaddr_q == REG_ADDR);
  wire wr_data = do_wr && (awaddr_q == REG_WDATA) && wstrb_q[0];
  wire wr_pwr = do_wr && (awaddr_q == REG_POWER) && wstrb_q[0];
  wire [31:0] addr_merge = (32'(addr_q) & ~wmask) | (bus_wdata_q & wmask);
  wire fci_op_e new_op = fci_op_e'(bus_wdata_q[2:0]);
  wire idle = (state_q == M_IDLE);
  wire susp_ok = susp_q ? OP_SUSP_OK_MASK[new_op] : (new_op != OP_RESUME);
  wire supply_ok = !(supply_low_q && OP_SUPPLY_MASK[new_op]);
  wire susp_win = state_q == M_POLL && op_q == OP_ERASE && new_op == OP_SUSPEND && !rb_s2_q;
  wire start_ok = (idle || susp_win) && !pwd_q && susp_ok && supply_ok;
  wire start = wr_cmd && start_ok;
  wire [31:0] stat_word = {16'h0000, sr_q, 2'b00, pwd_q, rb_s2_q, refused_q, supply_low_q,
    susp_q, !idle};
  wire [31:0] rd_word = (s_axi_araddr == REG_CMD) ? {29'h0, op_q} :
    (s_axi_araddr == REG_ADDR) ? 32'(addr_q) :
    (s_axi_araddr == REG_WDATA) ? {24'h0, wdata_q} :
    (s_axi_araddr == REG_RESULT) ? {24'h0, result_q} :
    (s_axi_araddr == REG_STATUS) ? stat_word :
    (s_axi_araddr == REG_POWER) ? {31'h0, pwd_q} : 32'h0;
  wire rd_hit = (s_axi_araddr <= REG_POWER) && (s_axi_araddr[1:0] == 2'b00);

  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready = !w_full_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign powerdown_input_n = !pwd_q;

  // ----------------------------------------
  // Cycle requests to the pin engine
  // ----------------------------------------
  assign cyc.req = req_q;
  assign cyc.wr = (state_q != M_READ);
  assign cyc.addr = addr_q; // Erase pair uses one in-block address
  assign cyc.wdata = (state_q != M_WR2) ? OP_CMD[op_q] :
    (op_q == OP_ERASE) ? CMD_CONFIRM : wdata_q;

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      bus_wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        bus_wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Operation sequencer
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    rb_s1_q <= ready_busy_output;
    rb_s2_q <= rb_s1_q;
    if (!aresetn) begin
      state_q <= M_IDLE;
      op_q <= OP_READ_ARRAY;
      req_q <= 1'b0;
      rb_cnt_q <= 4'h0;
    end else begin
      req_q <= 1'b0;
      unique case (state_q)
        M_IDLE: if (start) begin
          op_q <= new_op;
          req_q <= 1'b1;
          state_q <= M_WR1;
        end
        M_WR1: if (cyc.done) begin
          if (OP_W2_MASK[op_q]) begin
            req_q <= 1'b1;
            state_q <= M_WR2;
          end else if (OP_WAIT_MASK[op_q]) begin
            rb_cnt_q <= 4'h0;
            state_q <= M_SETTLE; // Suspend waits for pause point
          end else if (OP_READ_MASK[op_q]) begin
            req_q <= 1'b1;
            state_q <= M_READ; // Read-type ops fetch their byte
          end else begin
            state_q <= M_IDLE;
          end
        end
        M_WR2: if (cyc.done) begin
          rb_cnt_q <= 4'h0;
          state_q <= M_SETTLE; // Busy may not show before settle time
        end
        M_SETTLE: if (rb_cnt_q == RB_LAST) begin
          state_q <= M_POLL;
        end else begin
          rb_cnt_q <= rb_cnt_q + 4'h1;
        end
        M_POLL: if (rb_s2_q || start) begin
          req_q <= 1'b1;
          op_q <= start ? new_op : op_q; // Suspend may cut into an erase
          state_q <= start ? M_WR1 : M_READ; // Ready/busy high marks completion
        end
        M_READ: if (cyc.done) begin
          state_q <= M_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Host registers and status tracking
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_q <= '0;
      wdata_q <= 8'h00;
      result_q <= 8'h00;
      sr_q <= SR_RESET;
      supply_low_q <= 1'b0;
      susp_q <= 1'b0;
      refused_q <= 1'b0;
      pwd_q <= 1'b0;
    end else begin
      if (wr_addr) begin
        addr_q <= addr_merge[ADDR_W-1:0];
      end
      if (wr_data) begin
        wdata_q <= bus_wdata_q[7:0];
      end
      if (wr_pwr) begin
        pwd_q <= bus_wdata_q[0];
      end
      if (wr_cmd) begin
        refused_q <= !start_ok;
      end
      if (state_q == M_WR1 && cyc.done && op_q == OP_CLEAR) begin
        sr_q <= sr_q & ~SR_ERR_MASK;
        supply_low_q <= 1'b0;
      end
      if (state_q == M_WR1 && cyc.done && op_q == OP_RESUME) begin
        susp_q <= 1'b0;
      end
      if (state_q == M_READ && cyc.done) begin
        result_q <= cyc.rdata;
        if (OP_SR_MASK[op_q]) begin
          sr_q <= cyc.rdata & ~8'h07;
          supply_low_q <= supply_low_q | cyc.rdata[SR_SUPPLY_LOW_BIT];
        end
        if (op_q == OP_SUSPEND) begin
          susp_q <= cyc.rdata[SR_SUSP_BIT] & cyc.rdata[SR_READY_BIT];
        end
      end
      if (pwd_q) begin
        sr_q <= SR_RESET;
        supply_low_q <= 1'b0;
        susp_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  chk_low_supply_block: assert property (wr_cmd && supply_low_q &&
    (new_op == OP_ERASE || new_op == OP_WRITE) |=> refused_q && state_q == M_IDLE)
    else $error("write or erase issued with low supply flag set");
  chk_suspend_gate: assert property (wr_cmd && susp_q &&
    (new_op == OP_ERASE || new_op == OP_WRITE || new_op == OP_CLEAR) |=> refused_q)
    else $error("illegal command accepted while suspended");
  chk_ready_then_read: assert property (state_q == M_POLL && rb_s2_q |=>
    cyc.req && !cyc.wr)
    else $error("status read not issued after ready");
  chk_erase_confirm: assert property (state_q == M_WR2 && cyc.req && op_q == OP_ERASE
    |-> cyc.wdata == CMD_CONFIRM && cyc.wr)
    else $error("erase setup not followed by confirm");
  chk_settle_wait: assert property (state_q == M_WR2 && cyc.done |=>
    (state_q == M_SETTLE)[*2] ##1 state_q == M_POLL)
    else $error("ready polled before settle time");
  chk_clear_supply: assert property (state_q == M_WR1 && cyc.done && op_q == OP_CLEAR
    && !pwd_q |=> !supply_low_q && (sr_q & SR_ERR_MASK) == 8'h00)
    else $error("clear status left flags set");
  chk_single_cycle: assert property (cyc.req |=> !cyc.req ##1 !cyc.req)
    else $error("back to back cycle requests");

  cov_erase_done: cover property (state_q == M_READ && cyc.done && op_q == OP_ERASE);
  cov_write_done: cover property (state_q == M_READ && cyc.done && op_q == OP_WRITE);
  cov_suspended: cover property (susp_q && wr_cmd && new_op == OP_RESUME);
  cov_refused: cover property (wr_cmd && !start_ok);

endmodule

//--- test/fci_flash_model.sv
// Behavioural flash device seen by the host controller
`timescale 1ns/1ps
module fci_flash_model import fci_pkg::*; #(
  parameter logic [7:0] MFR_ID = 8'h11, // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'h22, // Arbitrary value
  parameter int BUSY_TICKS = 20
) (
  // Pins from host; program supply level from bench
  input wire logic [19:0] flash_addr,
  input wire logic [7:0] flash_dq_out,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic powerdown_input_n,
  input wire logic program_supply_high,
  // Pins to host
  output logic [7:0] flash_dq_in,
  output logic ready_busy_output
);
  logic [7:0] mem [256];
  logic [7:0] lat, hold, pend, c, wd, wa;
  logic [5:3] err;
  logic [1:0] mode;
  logic busy, susp, ers;
  int left;
  wire [7:0] stat = {!busy || susp, susp, err, 3'h0};
  wire rd = !chip_enable_n && !output_enable_n;
  wire [7:0] drv = mode == 2'h2 ? lat : mode == 2'h1 ? (flash_addr[0] ? DEV_ID : MFR_ID) :
    mem[flash_addr[7:0]];
  assign flash_dq_in = rd ? drv : hold;
  assign ready_busy_output = !busy || susp;
  task automatic clr();
    err = 3'h0;
    mode = 2'h0;
    pend = 8'h00;
    busy = 1'h0;
    susp = 1'h0;
  endtask
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    hold = 8'h00;
    lat = 8'h80;
    clr();
  end
  always @(negedge powerdown_input_n) clr();
  always @(negedge output_enable_n or negedge chip_enable_n)
    if (!chip_enable_n && !output_enable_n) lat = stat;
  always @(posedge output_enable_n or posedge chip_enable_n) hold = ~drv;
  always @(negedge program_supply_high) if (busy) begin
    busy = 1'h0;
    err[3] = 1'h1;
  end
  always #100 begin
    if (busy && !susp) left--;
    if (busy && left == 0) begin
      busy = 1'h0;
      if (ers) foreach (mem[i]) mem[i] = 8'hFF;
      else mem[wa] = mem[wa] & wd;
    end
  end
  always @(posedge write_enable_n) if (!chip_enable_n && powerdown_input_n) begin
    c = flash_dq_out;
    if (pend != 8'h00) begin
      mode = 2'h2;
      if (pend == CMD_ERASE_SETUP && c != CMD_CONFIRM) err[5:4] = 2'h3;
      else if (!program_supply_high) err[3] = 1'h1;
      else if (!err[3]) begin
        busy = 1'h1;
        left = BUSY_TICKS;
        ers = pend == CMD_ERASE_SETUP;
        wa = flash_addr[7:0];
        wd = c;
      end
      pend = 8'h00;
    end else if (busy) begin
      if (c == CMD_READ_STATUS) mode = 2'h2;
      else if (susp && c == CMD_READ_ARRAY) mode = 2'h0;
      else if (susp && c == CMD_CONFIRM) begin
        susp = 1'h0;
        mode = 2'h2;
      end else if (ers && c == CMD_SUSPEND) susp = 1'h1;
    end else case (c)
      CMD_READ_ARRAY: mode = 2'h0;
      CMD_READ_ID: mode = 2'h1;
      CMD_READ_STATUS: mode = 2'h2;
      CMD_CLEAR_STATUS: err = 3'h0;
      CMD_ERASE_SETUP, CMD_WRITE_SETUP, CMD_WRITE_SETUP_ALT: pend = c;
      default: ;
    endcase
  end
endmodule

//--- test/fci_flash_host_bench.sv
// Self-checking bench for the flash command host controller
`timescale 1ns/1ps
module fci_flash_host_bench import fci_pkg::*;;
  localparam logic [7:0] MFR = 8'h5A; // Arbitrary value
  localparam logic [7:0] DEV = 8'h3C; // Arbitrary value
  logic aclk = 0, aresetn = 0, program_supply_high = 1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d, st, rs;
  logic [19:0] flash_addr;
  logic [7:0] flash_dq_out, flash_dq_in;
  logic flash_dq_oe, chip_enable_n, output_enable_n, write_enable_n;
  logic powerdown_input_n, ready_busy_output;
  int fail_count = 0;
  int n_checks = 0;
  always #25 aclk = ~aclk;
  fci_flash_host u_fci_flash_host (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .flash_addr, .flash_dq_out,
    .flash_dq_oe, .flash_dq_in, .chip_enable_n, .output_enable_n, .write_enable_n,
    .powerdown_input_n, .ready_busy_output);
  fci_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV)) u_fci_flash_model (.flash_addr,
    .flash_dq_out, .chip_enable_n, .output_enable_n, .write_enable_n, .powerdown_input_n,
    .program_supply_high, .flash_dq_in, .ready_busy_output);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    s_axi_awvalid <= 1'h1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'h1;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_bready <= 1'h1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'h1) begin
        aw = 1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w && s_axi_wready === 1'h1) begin
        w = 1;
        s_axi_wvalid <= 1'h0;
      end
    end
    while (s_axi_bvalid !== 1'h1) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_arvalid <= 1'h1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic run(input logic [19:0] a, input logic [2:0] o);
    int i;
    wr(REG_ADDR, {12'h000, a});
    wr(REG_CMD, {29'h0, o});
    i = 0;
    do begin
      rd(REG_STATUS);
      i++;
    end while (d[0] !== 1'h0 && i < 500);
    check("poll limit", {31'h0, d[0]}, 32'h0);
    st = d;
    rd(REG_RESULT);
    rs = d;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_basic();
    rd(REG_STATUS);
    check("reset status", d, 32'h00008010);
    rd(8'h40);
    check("unmapped read", {30'h0, r}, {30'h0, RESP_SLVERR});
    wr(8'h40, 32'h0);
    check("unmapped write", {30'h0, r}, {30'h0, RESP_SLVERR});
    run(20'h00000, OP_READ_ID);
    check("maker code", rs, {24'h0, MFR});
    run(20'h00001, OP_READ_ID);
    check("part code", rs, {24'h0, DEV});
    $display("t_basic done");
  endtask
  task automatic t_write();
    wr(REG_WDATA, 32'hA5);
    run(20'h00005, OP_WRITE);
    check("write status", st[15:8], 8'h80);
    run(20'h00005, OP_READ_ARRAY);
    check("array byte", rs, 32'hA5);
    wr(REG_WDATA, 32'h0F);
    run(20'h00005, OP_WRITE);
    check("rewrite status", st[15:8], 8'h80);
    run(20'h00005, OP_READ_ARRAY);
    check("rewritten byte", rs, 32'h05);
    $display("t_write done");
  endtask
  task automatic t_erase();
    wr(REG_ADDR, 32'h5);
    wr(REG_CMD, {29'h0, OP_ERASE});
    wr(REG_CMD, {29'h0, OP_SUSPEND});
    rd(REG_STATUS);
    check("busy refusal", d[3:0], 4'h9);
    repeat (4) @(posedge aclk);
    check("busy pin", ready_busy_output, 1'h0);
    repeat (12) @(posedge aclk);
    run(20'h00005, OP_SUSPEND);
    check("suspend status", st[15:0], 16'hC012);
    check("suspend pin", ready_busy_output, 1'h1);
    wr(REG_CMD, {29'h0, OP_WRITE});
    rd(REG_STATUS);
    check("suspend refusal", d[3:0], 4'hA);
    run(20'h00005, OP_RESUME);
    check("resume status", st[15:0], 16'h8010);
    run(20'h00005, OP_READ_STATUS);
    check("erase status", st[15:8], 8'h80);
    run(20'h00005, OP_READ_ARRAY);
    check("erased byte", rs, 32'hFF);
    $display("t_erase done");
  endtask
  task automatic t_supply();
    program_supply_high <= 1'h0;
    run(20'h00006, OP_WRITE);
    check("low supply status", st[15:8], 8'h88);
    check("low supply flag", st[2], 1'h1);
    wr(REG_CMD, {29'h0, OP_WRITE});
    rd(REG_STATUS);
    check("supply refusal", d[3], 1'h1);
    run(20'h00006, OP_CLEAR);
    program_supply_high <= 1'h1;
    run(20'h00006, OP_READ_STATUS);
    check("cleared status", st[15:8] | {7'h0, st[2]}, 8'h80);
    $display("t_supply done");
  endtask
  task automatic t_power();
    wr(REG_POWER, 32'h1);
    check("powerdown pin", powerdown_input_n, 1'h0);
    rd(REG_STATUS);
    check("powerdown status", {d[15:8], d[5]}, 9'h101);
    wr(REG_POWER, 32'h0);
    run(20'h00000, OP_READ_STATUS);
    check("after wake", st[15:8], 8'h80);
    $display("t_power done");
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    t_basic();
    t_write();
    t_erase();
    t_supply();
    t_power();
    end_sim();
  end
  initial begin
    #1000000;
    fail_count++;
    end_sim();
  end
endmodule
